//--- rtl/simd_alu_pkg.sv
// constants and types shared by the saturating simd and packing datapath
package simd_alu_pkg;

	localparam int WORD_W = 32;
	localparam int HALF_W = 16;
	localparam int BYTE_W = 8;
	localparam int SHIFT_W = 5;
	localparam int ROT_SEL_W = 2;

	// signed 32-bit clamp limits
	localparam logic [31:0] SAT32_MAX = 32'h7fff_ffff;
	localparam logic [31:0] SAT32_MIN = 32'h8000_0000;
	// signed 16-bit clamp limits
	localparam logic [15:0] SAT16_MAX = 16'h7fff;
	localparam logic [15:0] SAT16_MIN = 16'h8000;
	// unsigned lane clamp limits
	localparam logic [15:0] USAT16_MAX = 16'hffff;
	localparam logic [7:0] USAT8_MAX = 8'hff;
	localparam logic [15:0] USAT16_MIN = 16'h0000;
	localparam logic [7:0] USAT8_MIN = 8'h00;

	// reset values
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic SAT_FLAG_RESET = 1'b0;

	// pack top-bottom: a zero shift field encodes a shift of 32
	localparam logic [5:0] PACK_TB_ZERO_SHIFT = 6'h20;

	typedef enum logic [4:0] {
		OP_NOP,
		OP_SAT_DOUBLE_ADD,
		OP_SAT_DOUBLE_SUB,
		OP_SIGNED_SAT_ADD_SUB_EXCHANGE,
		OP_SIGNED_SAT_SUB_ADD_EXCHANGE,
		OP_UNSIGNED_SAT_ADD_SUB_EXCHANGE,
		OP_UNSIGNED_SAT_SUB_ADD_EXCHANGE,
		OP_UNSIGNED_SAT_BYTE_ADD,
		OP_UNSIGNED_SAT_HALF_ADD,
		OP_UNSIGNED_SAT_BYTE_SUB,
		OP_UNSIGNED_SAT_HALF_SUB,
		OP_PACK_BOTTOM_TOP,
		OP_PACK_TOP_BOTTOM,
		OP_SIGN_BYTE_EXTEND_ADD,
		OP_ZERO_BYTE_EXTEND_ADD,
		OP_SIGN_HALF_EXTEND_ADD,
		OP_ZERO_HALF_EXTEND_ADD,
		OP_SIGN_DUAL_BYTE_EXTEND_ADD,
		OP_ZERO_DUAL_BYTE_EXTEND_ADD,
		OP_SIGN_EXTEND_BYTE_OP,
		OP_ZERO_EXTEND_BYTE_OP,
		OP_SIGN_EXTEND_HALF_OP,
		OP_ZERO_EXTEND_HALF_OP,
		OP_SIGN_DUAL_BYTE_EXTEND,
		OP_ZERO_DUAL_BYTE_EXTEND
	} alu_op_t;

	typedef enum logic [1:0] {
		EXT_BYTE,
		EXT_HALF,
		EXT_DUAL_BYTE
	} ext_kind_t;

endpackage

//--- rtl/simd_unit_if.sv
// operand and result bundle between the datapath and its lane and extend units
`timescale 1ns/1ns
interface simd_unit_if;
	import simd_alu_pkg::*;
	logic [31:0] lane_x;
	logic [31:0] lane_y;
	logic lane_half_mode;
	logic [1:0] lane_sub_sel;
	logic [31:0] lane_res;
	logic [3:0] lane_clamped;
	logic [31:0] ext_base;
	logic [31:0] ext_src;
	logic [1:0] ext_rot;
	ext_kind_t ext_kind;
	logic ext_signed;
	logic [31:0] ext_res;

	modport core (output lane_x, lane_y, lane_half_mode, lane_sub_sel, ext_base, ext_src, ext_rot, ext_kind,
		ext_signed, input lane_res, lane_clamped, ext_res);
	modport lane (input lane_x, lane_y, lane_half_mode, lane_sub_sel, output lane_res, lane_clamped);
	modport ext (input ext_base, ext_src, ext_rot, ext_kind, ext_signed, output ext_res);
endinterface

//--- rtl/unsigned_lane_sat.sv
// unsigned saturating add or subtract on four byte lanes or two halfword lanes
`timescale 1ns/1ns
module unsigned_lane_sat
	import simd_alu_pkg::*;
(
	simd_unit_if.lane u // operands and lane results
);

	logic [31:0] byte_res;
	logic [3:0] byte_clamp;
	logic [31:0] half_res;
	logic [1:0] half_clamp;

	// byte lanes share the low subtract select
	for (genvar i = 0; i < 4; i++) begin : g_byte
		logic [8:0] s;
		always_comb begin
			if (u.lane_sub_sel[0]) begin
				s = {1'b0, u.lane_x[i*8 +: 8]} - {1'b0, u.lane_y[i*8 +: 8]};
				byte_res[i*8 +: 8] = s[8] ? USAT8_MIN : s[7:0]; // see (RULE_12)
			end else begin
				s = {1'b0, u.lane_x[i*8 +: 8]} + {1'b0, u.lane_y[i*8 +: 8]};
				byte_res[i*8 +: 8] = s[8] ? USAT8_MAX : s[7:0]; // see (RULE_10)
			end
			byte_clamp[i] = s[8];
		end
	end

	// each halfword picks add or subtract on its own, which serves the exchange ops
	for (genvar h = 0; h < 2; h++) begin : g_half
		logic [16:0] s;
		always_comb begin
			if (u.lane_sub_sel[h]) begin
				s = {1'b0, u.lane_x[h*16 +: 16]} - {1'b0, u.lane_y[h*16 +: 16]};
				half_res[h*16 +: 16] = s[16] ? USAT16_MIN : s[15:0]; // see (RULE_11) see (RULE_08)
			end else begin
				s = {1'b0, u.lane_x[h*16 +: 16]} + {1'b0, u.lane_y[h*16 +: 16]};
				half_res[h*16 +: 16] = s[16] ? USAT16_MAX : s[15:0]; // see (RULE_09) see (RULE_08)
			end
			half_clamp[h] = s[16];
		end
	end

	assign u.lane_res = u.lane_half_mode ? half_res : byte_res;
	assign u.lane_clamped = u.lane_half_mode ? {2'b00, half_clamp} : byte_clamp;

endmodule // unsigned_lane_sat

//--- rtl/rotate_extend_unit.sv
// rotate, extract, extend and optionally accumulate onto a base word
`timescale 1ns/1ns
module rotate_extend_unit
	import simd_alu_pkg::*;
(
	simd_unit_if.ext u // source, base and extend controls
);

	logic [31:0] rot;
	logic [31:0] ext;

	always_comb begin
		unique case (u.ext_rot) // see (RULE_23)
			2'd0: rot = u.ext_src;
			2'd1: rot = {u.ext_src[7:0], u.ext_src[31:8]};
			2'd2: rot = {u.ext_src[15:0], u.ext_src[31:16]};
			2'd3: rot = {u.ext_src[23:0], u.ext_src[31:24]};
		endcase
		ext = WORD_RESET;
		unique case (u.ext_kind)
			EXT_BYTE: ext = {{24{u.ext_signed & rot[7]}}, rot[7:0]}; // see (RULE_21)
			EXT_HALF: ext = {{16{u.ext_signed & rot[15]}}, rot[15:0]}; // see (RULE_21)
			EXT_DUAL_BYTE: ext = {{8{u.ext_signed & rot[23]}}, rot[23:16], {8{u.ext_signed & rot[7]}}, rot[7:0]};
			default: ext = WORD_RESET;
		endcase
		// dual mode adds per halfword so no carry crosses bit 16
		if (u.ext_kind == EXT_DUAL_BYTE) begin
			u.ext_res = {u.ext_base[31:16] + ext[31:16], u.ext_base[15:0] + ext[15:0]}; // see (RULE_20)
		end else begin
			u.ext_res = u.ext_base + ext; // see (RULE_19)
		end
	end

endmodule // rotate_extend_unit

//--- rtl/saturating_simd_pack_alu.sv
// single-cycle saturating simd, pack and extend datapath with sticky saturation flag
//
// Summary of operation
// (RULE_01) signed exchange add/subtract never writes the condition code flags
// (RULE_02) double-add: second operand doubled, added to first, result written back
// (RULE_03) double-sub: second operand doubled, subtracted from first, result written back
// (RULE_04) doubling and add/sub each clamp to the signed 32-bit range
// (RULE_05) any clamp in either double-op step sets the sticky saturation flag
// (RULE_06) unsigned add-sub-exchange: top = a.bottom + b.top, bottom = a.top - b.bottom
// (RULE_07) unsigned sub-add-exchange: top = a.top - b.bottom, bottom = a.bottom + b.top
// (RULE_08) unsigned exchange lanes clamp to 0 through 65535
// (RULE_09) unsigned halfword add clamps each halfword sum to 0 through 65535
// (RULE_10) unsigned byte add clamps each of four byte sums to 0 through 255
// (RULE_11) unsigned halfword subtract clamps each halfword difference to 0 through 65535
// (RULE_12) unsigned byte subtract clamps each byte difference to 0 through 255
// (RULE_13) pack bottom-top: low half from first, high half from shifted second
// (RULE_14) pack bottom-top left shift of 1 to 31, zero means no shift
// (RULE_15) pack top-bottom: high half from first, low half from shifted second
// (RULE_16) pack top-bottom arithmetic right shift 1 to 32, zero field means 32
// (RULE_17) pack ops leave every status flag, sticky saturation included, unchanged
// (RULE_18) the issuer never targets stack pointer or program counter with a pack
// (RULE_19) single extend-add: extended low byte or half of second added to first
// (RULE_20) dual extend-add: two bytes extended to halves, added per halfword
// (RULE_21) plain extend gives a 32-bit sign or zero extended byte or halfword
// (RULE_22) sticky flag stays set; only an explicit status write clears it
// (RULE_23) extend ops rotate the source right by 0, 8, 16 or 24 first
// (RULE_24) a failed condition suppresses the register write and the flag update
// (RULE_25) result and saturation indication are computed in one cycle, presented together
`timescale 1ns/1ns
module saturating_simd_pack_alu
	import simd_alu_pkg::*;
(
	input wire logic clk_sys, // core clock
	input wire logic rst, // synchronous reset, active high
	input wire logic issue_valid, // one-cycle issue strobe
	input wire alu_op_t issue_op, // operation select
	input wire logic cond_pass, // condition code evaluated true
	input wire logic [31:0] operand_a, // first operand
	input wire logic [31:0] operand_b, // second operand
	input wire logic [4:0] shift_amt, // pack shift field
	input wire logic [1:0] rot_sel, // extend rotate, units of 8 bits
	input wire logic psr_write, // explicit status register write strobe
	input wire logic psr_write_sat, // value written to the saturation flag
	output logic wb_valid_r, // result presented this cycle
	output logic wb_we_r, // destination register write enable
	output logic [31:0] wb_data_r, // result word
	output logic wb_sat_r, // saturation occurred in this result
	output logic cond_flags_we_r, // condition code flag write enable
	output logic sat_flag_r // sticky saturation flag
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// returns {clamped, value}; overflow when the guard bits disagree with bit 31
	function automatic logic [32:0] sat_s32(input logic [33:0] v);
		if (v[33:31] == 3'b000 || v[33:31] == 3'b111) begin
			return {1'b0, v[31:0]};
		end
		return {1'b1, v[33] ? SAT32_MIN : SAT32_MAX};
	endfunction

	function automatic logic [16:0] sat_s16(input logic [17:0] v);
		if (v[17:15] == 3'b000 || v[17:15] == 3'b111) begin
			return {1'b0, v[15:0]};
		end
		return {1'b1, v[17] ? SAT16_MIN : SAT16_MAX};
	endfunction

	function automatic logic [17:0] sx18(input logic [15:0] h);
		return {{2{h[15]}}, h};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// sub units

	simd_unit_if unit_bus ();

	unsigned_lane_sat u_lane (
		.u(unit_bus.lane)
	);

	rotate_extend_unit u_ext (
		.u(unit_bus.ext)
	);

	////////////////////////////////////////////////////////////////////////////
	// operand steering to the sub units

	always_comb begin
		unit_bus.lane_x = operand_a;
		unit_bus.lane_y = operand_b;
		unit_bus.lane_half_mode = 1'b1;
		unit_bus.lane_sub_sel = 2'b00;
		unique case (issue_op)
			OP_UNSIGNED_SAT_ADD_SUB_EXCHANGE: begin
				unit_bus.lane_x = {operand_a[15:0], operand_a[31:16]}; // see (RULE_06)
				unit_bus.lane_y = {operand_b[31:16], operand_b[15:0]};
				unit_bus.lane_sub_sel = 2'b01;
			end
			OP_UNSIGNED_SAT_SUB_ADD_EXCHANGE: begin
				unit_bus.lane_x = operand_a; // see (RULE_07)
				unit_bus.lane_y = {operand_b[15:0], operand_b[31:16]};
				unit_bus.lane_sub_sel = 2'b10;
			end
			OP_UNSIGNED_SAT_HALF_SUB: unit_bus.lane_sub_sel = 2'b11;
			OP_UNSIGNED_SAT_BYTE_ADD: unit_bus.lane_half_mode = 1'b0;
			OP_UNSIGNED_SAT_BYTE_SUB: begin
				unit_bus.lane_half_mode = 1'b0;
				unit_bus.lane_sub_sel = 2'b11;
			end
			default: begin
				unit_bus.lane_half_mode = 1'b1;
			end
		endcase
	end

	always_comb begin
		unit_bus.ext_src = operand_b;
		unit_bus.ext_rot = rot_sel;
		unit_bus.ext_base = operand_a;
		unit_bus.ext_kind = EXT_BYTE;
		unit_bus.ext_signed = 1'b0;
		unique case (issue_op)
			OP_SIGN_BYTE_EXTEND_ADD: unit_bus.ext_signed = 1'b1;
			OP_SIGN_HALF_EXTEND_ADD: begin
				unit_bus.ext_kind = EXT_HALF;
				unit_bus.ext_signed = 1'b1;
			end
			OP_ZERO_HALF_EXTEND_ADD: unit_bus.ext_kind = EXT_HALF;
			OP_SIGN_DUAL_BYTE_EXTEND_ADD: begin
				unit_bus.ext_kind = EXT_DUAL_BYTE;
				unit_bus.ext_signed = 1'b1;
			end
			OP_ZERO_DUAL_BYTE_EXTEND_ADD: unit_bus.ext_kind = EXT_DUAL_BYTE;
			// plain extends add onto zero; the value to extend is still the second operand
			OP_SIGN_EXTEND_BYTE_OP: begin
				unit_bus.ext_base = WORD_RESET;
				unit_bus.ext_signed = 1'b1;
			end
			OP_ZERO_EXTEND_BYTE_OP: unit_bus.ext_base = WORD_RESET;
			OP_SIGN_EXTEND_HALF_OP: begin
				unit_bus.ext_base = WORD_RESET;
				unit_bus.ext_kind = EXT_HALF;
				unit_bus.ext_signed = 1'b1;
			end
			OP_ZERO_EXTEND_HALF_OP: begin
				unit_bus.ext_base = WORD_RESET;
				unit_bus.ext_kind = EXT_HALF;
			end
			OP_SIGN_DUAL_BYTE_EXTEND: begin
				unit_bus.ext_base = WORD_RESET;
				unit_bus.ext_kind = EXT_DUAL_BYTE;
				unit_bus.ext_signed = 1'b1;
			end
			OP_ZERO_DUAL_BYTE_EXTEND: begin
				unit_bus.ext_base = WORD_RESET;
				unit_bus.ext_kind = EXT_DUAL_BYTE;
			end
			default: begin
				unit_bus.ext_signed = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// signed arithmetic done in place

	logic [32:0] dbl_sat;
	logic [32:0] dadd_sat;
	logic [32:0] dsub_sat;
	logic [16:0] sx_top_add;
	logic [16:0] sx_top_sub;
	logic [16:0] sx_bot_add;
	logic [16:0] sx_bot_sub;
	logic [31:0] pack_bt_shifted;
	logic [31:0] pack_tb_shifted;
	logic [5:0] tb_shift;

	always_comb begin
		// 2*b fits 34 bits, so the first clamp sees the true doubled value
		dbl_sat = sat_s32({operand_b[31], operand_b, 1'b0}); // see (RULE_04)
		dadd_sat = sat_s32({{2{operand_a[31]}}, operand_a} + {{2{dbl_sat[31]}}, dbl_sat[31:0]}); // see (RULE_02)
		dsub_sat = sat_s32({{2{operand_a[31]}}, operand_a} - {{2{dbl_sat[31]}}, dbl_sat[31:0]}); // see (RULE_03)
		sx_top_add = sat_s16(sx18(operand_a[31:16]) + sx18(operand_b[15:0]));
		sx_top_sub = sat_s16(sx18(operand_a[31:16]) - sx18(operand_b[15:0]));
		sx_bot_add = sat_s16(sx18(operand_a[15:0]) + sx18(operand_b[31:16]));
		sx_bot_sub = sat_s16(sx18(operand_a[15:0]) - sx18(operand_b[31:16]));
		pack_bt_shifted = operand_b << shift_amt; // see (RULE_14)
		tb_shift = (shift_amt == 5'd0) ? PACK_TB_ZERO_SHIFT : {1'b0, shift_amt}; // see (RULE_16)
		pack_tb_shifted = 32'($signed(operand_b) >>> tb_shift);
	end

	////////////////////////////////////////////////////////////////////////////
	// result select

	logic [31:0] result;
	logic result_sat;
	logic sets_sticky;

	always_comb begin
		result = WORD_RESET;
		result_sat = 1'b0;
		sets_sticky = 1'b0;
		unique case (issue_op)
			OP_NOP: result = WORD_RESET;
			OP_SAT_DOUBLE_ADD: begin
				result = dadd_sat[31:0];
				result_sat = dbl_sat[32] | dadd_sat[32];
				sets_sticky = result_sat; // see (RULE_05)
			end
			OP_SAT_DOUBLE_SUB: begin
				result = dsub_sat[31:0];
				result_sat = dbl_sat[32] | dsub_sat[32];
				sets_sticky = result_sat; // see (RULE_05)
			end
			OP_SIGNED_SAT_ADD_SUB_EXCHANGE: begin
				result = {sx_top_add[15:0], sx_bot_sub[15:0]};
				result_sat = sx_top_add[16] | sx_bot_sub[16];
			end
			OP_SIGNED_SAT_SUB_ADD_EXCHANGE: begin
				result = {sx_top_sub[15:0], sx_bot_add[15:0]};
				result_sat = sx_top_sub[16] | sx_bot_add[16];
			end
			OP_UNSIGNED_SAT_ADD_SUB_EXCHANGE, OP_UNSIGNED_SAT_SUB_ADD_EXCHANGE, OP_UNSIGNED_SAT_BYTE_ADD,
			OP_UNSIGNED_SAT_HALF_ADD, OP_UNSIGNED_SAT_BYTE_SUB, OP_UNSIGNED_SAT_HALF_SUB: begin
				result = unit_bus.lane_res;
				result_sat = |unit_bus.lane_clamped;
			end
			OP_PACK_BOTTOM_TOP: result = {pack_bt_shifted[31:16], operand_a[15:0]}; // see (RULE_13)
			OP_PACK_TOP_BOTTOM: result = {operand_a[31:16], pack_tb_shifted[15:0]}; // see (RULE_15)
			default: result = unit_bus.ext_res;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// writeback and sticky flag

	logic wb_valid_nxt;
	logic wb_we_nxt;
	logic [31:0] wb_data_nxt;
	logic wb_sat_nxt;
	logic cond_flags_we_nxt;
	logic sat_flag_nxt;
	logic exec;

	always_comb begin
		exec = issue_valid & cond_pass & (issue_op != OP_NOP);
		wb_valid_nxt = issue_valid;
		wb_we_nxt = exec; // see (RULE_24)
		wb_data_nxt = result; // see (RULE_25)
		wb_sat_nxt = exec & result_sat; // see (RULE_25)
		// no op of this datapath writes the condition code flags
		cond_flags_we_nxt = 1'b0; // see (RULE_01)
		sat_flag_nxt = sat_flag_r;
		if (psr_write) begin
			sat_flag_nxt = psr_write_sat; // see (RULE_22)
		end
		// a clamping double op in the same cycle as a clearing write still leaves the flag set
		if (exec & sets_sticky) begin
			sat_flag_nxt = 1'b1; // see (RULE_22) see (RULE_24) see (RULE_17)
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wb_valid_r <= 1'b0;
			wb_we_r <= 1'b0;
			wb_data_r <= WORD_RESET;
			wb_sat_r <= 1'b0;
			cond_flags_we_r <= 1'b0;
			sat_flag_r <= SAT_FLAG_RESET;
		end else begin
			wb_valid_r <= wb_valid_nxt;
			wb_we_r <= wb_we_nxt;
			wb_data_r <= wb_data_nxt;
			wb_sat_r <= wb_sat_nxt;
			cond_flags_we_r <= cond_flags_we_nxt;
			sat_flag_r <= sat_flag_nxt;
		end
	end

endmodule // saturating_simd_pack_alu

//--- tb/simd_alu_props.sv
// concurrent checks on the ports of the saturating simd and pack datapath
`timescale 1ns/1ns
module simd_alu_props
	import simd_alu_pkg::*;
(
	input wire logic clk_sys, // core clock
	input wire logic rst, // synchronous reset
	input wire logic issue_valid, // issue strobe
	input wire alu_op_t issue_op, // operation select
	input wire logic cond_pass, // condition true
	input wire logic [31:0] operand_a, // first operand
	input wire logic [31:0] operand_b, // second operand
	input wire logic [4:0] shift_amt, // pack shift field
	input wire logic [1:0] rot_sel, // extend rotate
	input wire logic psr_write, // status write strobe
	input wire logic psr_write_sat, // status write value
	input wire logic wb_valid_r, // result presented
	input wire logic wb_we_r, // register write enable
	input wire logic [31:0] wb_data_r, // result word
	input wire logic wb_sat_r, // clamp in this result
	input wire logic cond_flags_we_r, // condition flag write
	input wire logic sat_flag_r // sticky saturation flag
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_valid_next_cycle: assert property (issue_valid |=> wb_valid_r)
		else $error("result not presented one cycle after issue");
	a_idle_no_write: assert property (!issue_valid |=> !wb_valid_r && !wb_we_r && !wb_sat_r)
		else $error("writeback without an issue");
	a_we_follows: assert property (issue_valid && cond_pass && issue_op != OP_NOP |=> wb_we_r)
		else $error("executed op did not write");
	a_refused_no_write: assert property (issue_valid && !cond_pass |=> !wb_we_r && !wb_sat_r)
		else $error("failed condition still wrote");
	a_refused_keeps_flag: assert property (issue_valid && !cond_pass && !psr_write |=> $stable(sat_flag_r))
		else $error("failed condition moved sticky flag");
	a_flags_untouched: assert property (cond_flags_we_r == 1'b0)
		else $error("condition flags written");
	a_pack_keeps_flag: assert property (issue_valid && !psr_write &&
		(issue_op == OP_PACK_BOTTOM_TOP || issue_op == OP_PACK_TOP_BOTTOM) |=> $stable(sat_flag_r) && !wb_sat_r)
		else $error("pack changed saturation state");
	a_sticky_holds: assert property (sat_flag_r && !psr_write |=> sat_flag_r)
		else $error("sticky flag cleared without status write");
	a_flag_rise_cause: assert property ($rose(sat_flag_r) |-> wb_sat_r || $past(psr_write))
		else $error("sticky flag set without cause");
	a_double_sets_flag: assert property (wb_sat_r && ($past(issue_op) == OP_SAT_DOUBLE_ADD ||
		$past(issue_op) == OP_SAT_DOUBLE_SUB) |-> sat_flag_r)
		else $error("double op clamp missed sticky flag");
	a_pack_low_half: assert property (issue_valid && issue_op == OP_PACK_BOTTOM_TOP |=>
		wb_data_r[15:0] == $past(operand_a[15:0]))
		else $error("bottom-top pack low half wrong");
	a_pack_high_half: assert property (issue_valid && issue_op == OP_PACK_TOP_BOTTOM |=>
		wb_data_r[31:16] == $past(operand_a[31:16]))
		else $error("top-bottom pack high half wrong");
endmodule // simd_alu_props

bind saturating_simd_pack_alu simd_alu_props u_props (.clk_sys(clk_sys), .rst(rst), .issue_valid(issue_valid),
	.issue_op(issue_op), .cond_pass(cond_pass), .operand_a(operand_a), .operand_b(operand_b), .shift_amt(shift_amt),
	.rot_sel(rot_sel), .psr_write(psr_write), .psr_write_sat(psr_write_sat), .wb_valid_r(wb_valid_r),
	.wb_we_r(wb_we_r), .wb_data_r(wb_data_r), .wb_sat_r(wb_sat_r), .cond_flags_we_r(cond_flags_we_r),
	.sat_flag_r(sat_flag_r));

//--- tb/core_regfile_model.sv
// register file writeback sink standing in for the issuing core
`timescale 1ns/1ns
module core_regfile_model (
	input wire logic clk_sys, // core clock
	input wire logic rst, // synchronous reset
	input wire logic wb_we_r, // destination write enable
	input wire logic [3:0] dest_idx, // destination register index
	output int unsigned writes // results accepted
);
	// stack pointer is 13, program counter 15; neither is ever a destination
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			writes <= 0;
		end else if (wb_we_r && dest_idx != 4'hd && dest_idx != 4'hf) begin
			writes <= writes + 1;
		end
	end
endmodule // core_regfile_model

//--- tb/tb_top.sv
// self-checking testbench for the saturating simd, pack and extend datapath
`timescale 1ns/1ns
module tb_top;
	import simd_alu_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic issue_valid = 1'b0;
	alu_op_t issue_op = OP_NOP;
	logic cond_pass = 1'b0;
	logic [31:0] operand_a = 32'h0000_0000;
	logic [31:0] operand_b = 32'h0000_0000;
	logic [4:0] shift_amt = 5'h00;
	logic [1:0] rot_sel = 2'h0;
	logic psr_write = 1'b0;
	logic psr_write_sat = 1'b0;
	logic wb_valid_r, wb_we_r, wb_sat_r, cond_flags_we_r, sat_flag_r;
	logic [31:0] wb_data_r;
	int unsigned writes;
	int errors = 0;
	int checked = 0;

	always #5 clk_sys = ~clk_sys;

	saturating_simd_pack_alu u_dut (.clk_sys(clk_sys), .rst(rst), .issue_valid(issue_valid), .issue_op(issue_op),
		.cond_pass(cond_pass), .operand_a(operand_a), .operand_b(operand_b), .shift_amt(shift_amt),
		.rot_sel(rot_sel), .psr_write(psr_write), .psr_write_sat(psr_write_sat), .wb_valid_r(wb_valid_r),
		.wb_we_r(wb_we_r), .wb_data_r(wb_data_r), .wb_sat_r(wb_sat_r), .cond_flags_we_r(cond_flags_we_r),
		.sat_flag_r(sat_flag_r));
	core_regfile_model u_core (.clk_sys(clk_sys), .rst(rst), .wb_we_r(wb_we_r), .dest_idx(4'h3), .writes(writes));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic run_op(alu_op_t op, logic [31:0] a, logic [31:0] b, logic [4:0] sh, logic [1:0] rot, logic cp,
		logic [31:0] exp_d, logic exp_s);
		@(posedge clk_sys);
		issue_valid <= 1'b1;
		issue_op <= op;
		operand_a <= a;
		operand_b <= b;
		shift_amt <= sh;
		rot_sel <= rot;
		cond_pass <= cp;
		@(posedge clk_sys);
		issue_valid <= 1'b0;
		#1;
		chk({28'h0, wb_valid_r, wb_we_r, wb_sat_r, cond_flags_we_r}, {28'h0, 1'b1, cp, exp_s, 1'b0});
		if (cp) chk(wb_data_r, exp_d);
	endtask

	task automatic psr(logic v);
		@(posedge clk_sys);
		psr_write <= 1'b1;
		psr_write_sat <= v;
		@(posedge clk_sys);
		psr_write <= 1'b0;
		#1;
		chk({31'h0, sat_flag_r}, {31'h0, v});
	endtask

	task automatic flag_is(logic v);
		chk({31'h0, sat_flag_r}, {31'h0, v});
	endtask

	// extend reference: rotate, extract, extend, optionally accumulate
	function automatic logic [31:0] ext_ref(alu_op_t op, logic [31:0] a, logic [31:0] b, logic [1:0] rot);
		logic [31:0] r, eb, eh, ed;
		logic s;
		r = (b >> (8 * rot)) | (b << (32 - 8 * rot));
		s = op inside {OP_SIGN_BYTE_EXTEND_ADD, OP_SIGN_HALF_EXTEND_ADD, OP_SIGN_DUAL_BYTE_EXTEND_ADD,
			OP_SIGN_EXTEND_BYTE_OP, OP_SIGN_EXTEND_HALF_OP, OP_SIGN_DUAL_BYTE_EXTEND};
		eb = {{24{s & r[7]}}, r[7:0]};
		eh = {{16{s & r[15]}}, r[15:0]};
		ed = {{8{s & r[23]}}, r[23:16], {8{s & r[7]}}, r[7:0]};
		case (op)
			OP_SIGN_BYTE_EXTEND_ADD, OP_ZERO_BYTE_EXTEND_ADD: return a + eb;
			OP_SIGN_HALF_EXTEND_ADD, OP_ZERO_HALF_EXTEND_ADD: return a + eh;
			OP_SIGN_DUAL_BYTE_EXTEND_ADD, OP_ZERO_DUAL_BYTE_EXTEND_ADD: return {a[31:16] + ed[31:16], a[15:0] + ed[15:0]};
			OP_SIGN_EXTEND_BYTE_OP, OP_ZERO_EXTEND_BYTE_OP: return eb;
			OP_SIGN_EXTEND_HALF_OP, OP_ZERO_EXTEND_HALF_OP: return eh;
			default: return ed;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_double();
		psr(1'b0);
		run_op(OP_SAT_DOUBLE_ADD, 32'h0000_0001, 32'h0000_0002, 5'h00, 2'h0, 1'b1, 32'h0000_0005, 1'b0);
		flag_is(1'b0);
		run_op(OP_SAT_DOUBLE_ADD, 32'h8000_0000, 32'h4000_0000, 5'h00, 2'h0, 1'b1, 32'hffff_ffff, 1'b1);
		flag_is(1'b1);
		psr(1'b0);
		run_op(OP_SAT_DOUBLE_ADD, 32'h7fff_0000, 32'h0000_8000, 5'h00, 2'h0, 1'b1, 32'h7fff_ffff, 1'b1);
		run_op(OP_SAT_DOUBLE_SUB, 32'h0000_000a, 32'h0000_0003, 5'h00, 2'h0, 1'b1, 32'h0000_0004, 1'b0);
		run_op(OP_SAT_DOUBLE_SUB, 32'h0000_0000, 32'h4000_0000, 5'h00, 2'h0, 1'b1, 32'h8000_0001, 1'b1);
		run_op(OP_SAT_DOUBLE_SUB, 32'h8000_0000, 32'h0000_0001, 5'h00, 2'h0, 1'b1, 32'h8000_0000, 1'b1);
		flag_is(1'b1);
	endtask

	// unsigned clamps report in wb_sat_r but leave the sticky flag alone
	task automatic t_unsigned();
		psr(1'b0);
		run_op(OP_UNSIGNED_SAT_ADD_SUB_EXCHANGE, 32'h0001_ffff, 32'h0005_0002, 5'h00, 2'h0, 1'b1,
			32'hffff_0000, 1'b1);
		run_op(OP_UNSIGNED_SAT_SUB_ADD_EXCHANGE, 32'h0009_0003, 32'h0004_0002, 5'h00, 2'h0, 1'b1,
			32'h0007_0007, 1'b0);
		run_op(OP_UNSIGNED_SAT_SUB_ADD_EXCHANGE, 32'h0001_fff0, 32'h0100_0002, 5'h00, 2'h0, 1'b1,
			32'h0000_ffff, 1'b1);
		run_op(OP_SIGNED_SAT_ADD_SUB_EXCHANGE, 32'h7fff_0001, 32'h0002_0003, 5'h00, 2'h0, 1'b1,
			32'h7fff_ffff, 1'b1);
		run_op(OP_SIGNED_SAT_SUB_ADD_EXCHANGE, 32'h7fff_0001, 32'h0002_0003, 5'h00, 2'h0, 1'b1,
			32'h7ffc_0003, 1'b0);
		run_op(OP_UNSIGNED_SAT_BYTE_ADD, 32'h80ff_1001, 32'h8001_2002, 5'h00, 2'h0, 1'b1, 32'hffff_3003, 1'b1);
		run_op(OP_UNSIGNED_SAT_HALF_ADD, 32'h7000_0001, 32'h9000_0002, 5'h00, 2'h0, 1'b1, 32'hffff_0003, 1'b1);
		run_op(OP_UNSIGNED_SAT_BYTE_SUB, 32'h0510_2003, 32'h0620_1001, 5'h00, 2'h0, 1'b1, 32'h0000_1002, 1'b1);
		run_op(OP_UNSIGNED_SAT_HALF_SUB, 32'h0010_8000, 32'h0020_0001, 5'h00, 2'h0, 1'b1, 32'h0000_7fff, 1'b1);
		flag_is(1'b0);
	endtask

	task automatic t_pack();
		psr(1'b1);
		run_op(OP_PACK_BOTTOM_TOP, 32'h1111_2222, 32'h3333_4444, 5'h00, 2'h0, 1'b1, 32'h3333_2222, 1'b0);
		run_op(OP_PACK_BOTTOM_TOP, 32'h1111_2222, 32'h3333_4444, 5'h04, 2'h0, 1'b1, 32'h3334_2222, 1'b0);
		run_op(OP_PACK_BOTTOM_TOP, 32'h1111_2222, 32'h0000_0001, 5'h1f, 2'h0, 1'b1, 32'h8000_2222, 1'b0);
		run_op(OP_PACK_TOP_BOTTOM, 32'h1111_2222, 32'h8765_4321, 5'h00, 2'h0, 1'b1, 32'h1111_ffff, 1'b0);
		run_op(OP_PACK_TOP_BOTTOM, 32'h1111_2222, 32'h8765_4321, 5'h10, 2'h0, 1'b1, 32'h1111_8765, 1'b0);
		run_op(OP_PACK_TOP_BOTTOM, 32'h1111_2222, 32'h8765_4321, 5'h01, 2'h0, 1'b1, 32'h1111_a190, 1'b0);
		flag_is(1'b1);
	endtask

	// low half of the base overflows so a carry into the top half would show
	task automatic t_extend();
		for (int i = int'(OP_SIGN_BYTE_EXTEND_ADD); i <= int'(OP_ZERO_DUAL_BYTE_EXTEND); i++) begin
			for (int r = 0; r < 4; r++) begin
				run_op(alu_op_t'(i), 32'h1234_ffff, 32'h8012_34f0, 5'h00, 2'(r), 1'b1,
					ext_ref(alu_op_t'(i), 32'h1234_ffff, 32'h8012_34f0, 2'(r)), 1'b0);
			end
		end
	endtask

	task automatic t_cond();
		int unsigned w;
		psr(1'b0);
		w = writes;
		run_op(OP_SAT_DOUBLE_ADD, 32'h0000_0000, 32'h4000_0000, 5'h00, 2'h0, 1'b0, 32'h0000_0000, 1'b0);
		flag_is(1'b0);
		@(posedge clk_sys);
		#1;
		chk(writes, w);
	endtask

	// a clear in the cycle of a clamping double op loses
	task automatic t_set_wins();
		psr(1'b0);
		@(posedge clk_sys);
		psr_write <= 1'b1;
		psr_write_sat <= 1'b0;
		issue_valid <= 1'b1;
		issue_op <= OP_SAT_DOUBLE_SUB;
		operand_a <= 32'h0000_0000;
		operand_b <= 32'h4000_0000;
		cond_pass <= 1'b1;
		@(posedge clk_sys);
		psr_write <= 1'b0;
		issue_valid <= 1'b0;
		#1;
		flag_is(1'b1);
		chk(wb_data_r, 32'h8000_0001);
	endtask

	task automatic end_of_test();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		t_double();
		t_unsigned();
		t_pack();
		t_extend();
		t_cond();
		t_set_wins();
		end_of_test();
	end

	// roughly 160 cycles of traffic; about twelve times that means a hang
	initial begin
		repeat (2000) @(posedge clk_sys);
		errors++;
		end_of_test();
	end
endmodule // tb_top
